// ### src/cfs_pkg.sv
// Contract
// R1: Missing system control power flags a system error, alarm and lamp.
// R2: Panel start restoring power clears the system error, initialises all devices.
// R3: Device errors stay local but still sound alarm and light lamp.
// R4: Alarm-clear press clears pending device errors, reinitialising only those devices.
// R5: Photoeye missing an expected load during any transfer gives code 01.
// R6: Mating machine cancelling a networked transfer gives code 01.
// R7: Hand loader: load-done and data-good still on after discharge give 02.
// R8: Hand loader: no load seen after load-done gives code 03.
// R9: Photoeye still blocked after discharge finishes gives code 04.
// R10: Linear belt: transfer cancelled before completion gives code 05.
// R11: Linear belt: no cake seen while discharging gives code 06.
// R12: Linear belt with outlet check: outlet eye blocked while loading gives 07.
// R13: Linear belt: next expected cake not seen after discharge gives 08.
// R14: Device control power loss gives 09; device initialises on restore.
// R15: Hand switch shows code 10, halts automatic, no alarm; init on release.
// R16: Manual mode halts sequencing, reports inputs, drives outputs individually.
// R17: Program memory write permit is permanently asserted.
// R18: Latest error code latched until cleared; alarm driven while any pending. (The code keeps the first code found; only power loss overwrites it.)
package cfs_pkg;
    localparam int NDEV  = 4;
    localparam int OUTW  = 4;
    localparam int CW    = 4;
    localparam int AW    = 8;
    localparam int DW    = 32;
    localparam int FW    = 8;

    typedef logic [CW-1:0] cfs_code_type;
    localparam cfs_code_type ERR_NONE    = 4'h0;
    localparam cfs_code_type ERR_NOXFER  = 4'h1;
    localparam cfs_code_type ERR_NORESET = 4'h2;
    localparam cfs_code_type ERR_NOGOODS = 4'h3;
    localparam cfs_code_type ERR_EYEBLK  = 4'h4;
    localparam cfs_code_type ERR_ABORT   = 4'h5;
    localparam cfs_code_type ERR_NOCAKE  = 4'h6;
    localparam cfs_code_type ERR_OUTEYE  = 4'h7;
    localparam cfs_code_type ERR_MISSING = 4'h8;
    localparam cfs_code_type ERR_PWR     = 4'h9;
    localparam cfs_code_type ERR_HAND    = 4'hA;

    typedef struct packed {
        logic ctlPower;
        logic handSw;
        logic eye;
        logic outEye;
        logic loadDone;
        logic dataGood;
        logic mateCancel;
        logic abortReq;
    } cfs_field_type;

    typedef struct packed {
        logic loading;
        logic discharging;
        logic dischDone;
        logic chkEye;
        logic nextChk;
    } cfs_seq_type;

    typedef struct packed {
        logic handLoader;
        logic linear;
        logic outChk;
    } cfs_cfg_type;

    typedef enum logic [1:0] {
        SYS_RUN  = 2'b00,
        SYS_DOWN = 2'b01,
        SYS_INIT = 2'b11
    } cfs_sys_type;

    localparam logic [AW-1:0] REG_CTRL  = 8'h00;
    localparam logic [AW-1:0] REG_STAT  = 8'h04;
    localparam logic [AW-1:0] REG_TYPE  = 8'h08;
    localparam logic [AW-1:0] REG_CODE  = 8'h0C;
    localparam logic [AW-1:0] REG_MOUT  = 8'h10;
    localparam logic [AW-1:0] REG_INP   = 8'h14;
    localparam logic [AW-1:0] REG_ISTAT = 8'h18;
    localparam logic [AW-1:0] REG_IMASK = 8'h1C;
    localparam logic [AW-1:0] REG_CMD   = 8'h20;

    localparam int CTRL_MAN     = 0;
    localparam int CMD_CANCEL   = 0;
    localparam int TYPE_HAND    = 0;
    localparam int TYPE_LIN     = 8;
    localparam int TYPE_CHK     = 16;
    localparam int STAT_SYS     = 0;
    localparam int STAT_ALARM   = 1;
    localparam int STAT_3W      = 2;
    localparam int STAT_AUTO    = 8;
    localparam int ISTAT_SYS    = 0;
    localparam int ISTAT_DEV    = 1;
endpackage : cfs_pkg

// ### src/cfs_supervisor.sv
`timescale 1ns/1ps
module cfs_supervisor (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [cfs_pkg::AW-1:0]      paddr,
    input  wire logic [cfs_pkg::DW-1:0]      pwdata,
    output logic      [cfs_pkg::DW-1:0]      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Panel pins
    input  wire logic                        threeWirePin,
    input  wire logic                        cancelPin,
    output logic                             signalOut,
    output logic                             progPermit,
    output logic                             irq,
    // Field pins, one struct per device
    input  wire cfs_pkg::cfs_field_type [cfs_pkg::NDEV-1:0] fieldPin,
    // Sequencer side, same clock
    input  wire cfs_pkg::cfs_seq_type   [cfs_pkg::NDEV-1:0] seqIn,
    input  wire logic [cfs_pkg::NDEV*cfs_pkg::OUTW-1:0]     autoOut,
    output logic      [cfs_pkg::NDEV*cfs_pkg::OUTW-1:0]     devOut,
    output logic      [cfs_pkg::NDEV-1:0]    autoRun,
    output logic      [cfs_pkg::NDEV-1:0]    devInit
);
    localparam int N  = cfs_pkg::NDEV;
    localparam int MW = cfs_pkg::NDEV * cfs_pkg::OUTW;

    // Error priority: linear-belt abort first, then mate cancel, then the other linear-belt checks
    function automatic cfs_pkg::cfs_code_type detectErr(
        cfs_pkg::cfs_field_type f,
        cfs_pkg::cfs_seq_type   s,
        cfs_pkg::cfs_cfg_type   c);
        logic xfer;
        begin
            xfer = s.loading | s.discharging;
            if (c.linear & xfer & f.abortReq)
                detectErr = cfs_pkg::ERR_ABORT; // R10
            else if (xfer & f.mateCancel)
                detectErr = cfs_pkg::ERR_NOXFER; // R6
            else if (c.linear & c.outChk & s.loading & f.outEye)
                detectErr = cfs_pkg::ERR_OUTEYE; // R12
            else if (c.linear & s.discharging & s.chkEye & !f.eye)
                detectErr = cfs_pkg::ERR_NOCAKE; // R11
            else if (c.linear & s.nextChk & !f.eye)
                detectErr = cfs_pkg::ERR_MISSING; // R13
            else if (c.handLoader & s.dischDone & f.loadDone & f.dataGood)
                detectErr = cfs_pkg::ERR_NORESET; // R7
            else if (s.dischDone & f.eye)
                detectErr = cfs_pkg::ERR_EYEBLK; // R9
            else if (c.handLoader & f.loadDone & s.chkEye & !f.eye)
                detectErr = cfs_pkg::ERR_NOGOODS; // R8
            else if (xfer & s.chkEye & !f.eye)
                detectErr = cfs_pkg::ERR_NOXFER; // R5
            else
                detectErr = cfs_pkg::ERR_NONE;
        end
    endfunction : detectErr

    function automatic logic isAlarm(cfs_pkg::cfs_code_type c);
        isAlarm = (c != cfs_pkg::ERR_NONE) && (c != cfs_pkg::ERR_HAND);
    endfunction : isAlarm

    // Pin synchronisers; stage one is read only by stage two
    logic [N*cfs_pkg::FW-1:0] fieldMeta_r;
    logic [N*cfs_pkg::FW-1:0] fieldSync_r;
    logic                     threeMeta_r;
    logic                     threeSync_r;
    logic                     cancelMeta_r;
    logic                     cancelSync_r;
    logic                     cancelLast_r;

    always_ff @(posedge core_clk) begin
        fieldMeta_r  <= fieldPin;
        fieldSync_r  <= fieldMeta_r;
        threeMeta_r  <= threeWirePin;
        threeSync_r  <= threeMeta_r;
        cancelMeta_r <= cancelPin;
        cancelSync_r <= cancelMeta_r;
        cancelLast_r <= reset ? 1'b0 : cancelSync_r;
    end

    cfs_pkg::cfs_field_type [N-1:0] fieldS;
    assign fieldS = fieldSync_r;

    // Registers
    logic                     manual_r;
    logic [N-1:0]             typeHand_r;
    logic [N-1:0]             typeLin_r;
    logic [N-1:0]             typeChk_r;
    logic [MW-1:0]            mout_r;
    logic [N:0]               istat_r;
    logic [N:0]               imask_r;
    cfs_pkg::cfs_sys_type     sys_r;
    cfs_pkg::cfs_sys_type     sys_nxt;
    cfs_pkg::cfs_code_type    code_r   [N];
    cfs_pkg::cfs_code_type    code_nxt [N];

    // Bus decode
    wire access   = psel & penable;
    wire wrEn     = access & pwrite & pready;
    wire selCtrl  = paddr == cfs_pkg::REG_CTRL;
    wire selStat  = paddr == cfs_pkg::REG_STAT;
    wire selType  = paddr == cfs_pkg::REG_TYPE;
    wire selCode  = paddr == cfs_pkg::REG_CODE;
    wire selMout  = paddr == cfs_pkg::REG_MOUT;
    wire selInp   = paddr == cfs_pkg::REG_INP;
    wire selIstat = paddr == cfs_pkg::REG_ISTAT;
    wire selImask = paddr == cfs_pkg::REG_IMASK;
    wire selCmd   = paddr == cfs_pkg::REG_CMD;
    wire mapped   = selCtrl | selStat | selType | selCode | selMout
                  | selInp | selIstat | selImask | selCmd;

    // Panel button or software both count as alarm clear
    wire swCancel = wrEn & selCmd & pwdata[cfs_pkg::CMD_CANCEL];
    wire cancelEv = swCancel | (cancelSync_r & ~cancelLast_r);

    // System power supervision
    wire sysErr  = sys_r != cfs_pkg::SYS_RUN;
    wire sysInit = sys_r == cfs_pkg::SYS_INIT;

    always_comb begin
        case (sys_r)
            cfs_pkg::SYS_RUN:
                sys_nxt = threeSync_r ? cfs_pkg::SYS_RUN
                                      : cfs_pkg::SYS_DOWN; // R1
            cfs_pkg::SYS_DOWN:
                sys_nxt = threeSync_r ? cfs_pkg::SYS_INIT
                                      : cfs_pkg::SYS_DOWN; // R2
            cfs_pkg::SYS_INIT:
                sys_nxt = threeSync_r ? cfs_pkg::SYS_RUN
                                      : cfs_pkg::SYS_DOWN;
            default:
                sys_nxt = cfs_pkg::SYS_DOWN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        sys_r <= reset ? cfs_pkg::SYS_RUN : sys_nxt;
    end

    // Per-device error state
    logic [N-1:0]   initEv;
    logic [N-1:0]   alarmDev;
    logic [N-1:0]   alarmNew;
    logic [N-1:0]   runDev;
    logic [N*cfs_pkg::CW-1:0] codeFlat;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gDev
            cfs_pkg::cfs_cfg_type  cfg;
            cfs_pkg::cfs_code_type found;
            wire detectOn = (sys_r == cfs_pkg::SYS_RUN) & ~manual_r;

            assign cfg = '{handLoader: typeHand_r[g],
                           linear:     typeLin_r[g],
                           outChk:     typeChk_r[g]};
            assign found = detectErr(fieldS[g], seqIn[g], cfg);

            always_comb begin
                code_nxt[g] = code_r[g];
                initEv[g]   = 1'b0;
                if (!fieldS[g].ctlPower) begin
                    code_nxt[g] = cfs_pkg::ERR_PWR; // R14
                end else if (sysInit) begin
                    code_nxt[g] = cfs_pkg::ERR_NONE; // R2
                    initEv[g]   = 1'b1;
                end else if (code_r[g] == cfs_pkg::ERR_PWR) begin
                    code_nxt[g] = cfs_pkg::ERR_NONE; // R14
                    initEv[g]   = 1'b1;
                end else if (fieldS[g].handSw) begin
                    if (code_r[g] == cfs_pkg::ERR_NONE)
                        code_nxt[g] = cfs_pkg::ERR_HAND; // R15
                end else if (code_r[g] == cfs_pkg::ERR_HAND) begin
                    code_nxt[g] = cfs_pkg::ERR_NONE; // R15
                    initEv[g]   = 1'b1;
                end else if (cancelEv && code_r[g] != cfs_pkg::ERR_NONE) begin
                    code_nxt[g] = cfs_pkg::ERR_NONE; // R4
                    initEv[g]   = 1'b1;
                end else if (detectOn && code_r[g] == cfs_pkg::ERR_NONE) begin
                    code_nxt[g] = found; // R18
                end
            end

            // Errors stay per device; others keep running
            assign alarmDev[g] = isAlarm(code_r[g]); // R3
            assign alarmNew[g] = isAlarm(code_nxt[g]) & ~alarmDev[g];
            assign runDev[g]   = (code_r[g] == cfs_pkg::ERR_NONE)
                               & ~sysErr & ~manual_r; // R16
            assign codeFlat[g*cfs_pkg::CW +: cfs_pkg::CW] = code_r[g];

            always_ff @(posedge core_clk) begin
                code_r[g] <= reset ? cfs_pkg::ERR_NONE : code_nxt[g];
            end
        end
    endgenerate

    // Interrupt status: set wins over write-one-to-clear
    wire [N:0] istatSet = {alarmNew,
                           (sys_nxt == cfs_pkg::SYS_DOWN) & ~sysErr};
    wire [N:0] istatClr = (wrEn & selIstat) ? pwdata[N:0] : '0;
    wire [N:0] istatNxt = (istat_r & ~istatClr) | istatSet;

    wire alarmNxt = sysErr | (|alarmDev); // R1 R3 R18

    // Manual mode takes outputs from the register, not the sequencer
    wire [MW-1:0] outNxt;
    generate
        for (g = 0; g < N; g++) begin : gOut
            assign outNxt[g*cfs_pkg::OUTW +: cfs_pkg::OUTW] =
                manual_r ? mout_r[g*cfs_pkg::OUTW +: cfs_pkg::OUTW] // R16
                         : (runDev[g]
                            ? autoOut[g*cfs_pkg::OUTW +: cfs_pkg::OUTW]
                            : '0);
        end
    endgenerate

    // Read mux
    wire [cfs_pkg::DW-1:0] statWord =
        {{(cfs_pkg::DW-cfs_pkg::STAT_AUTO-N){1'b0}}, runDev,
         {(cfs_pkg::STAT_AUTO-cfs_pkg::STAT_3W-1){1'b0}},
         threeSync_r, signalOut, sysErr};
    wire [cfs_pkg::DW-1:0] typeWord =
        {{(cfs_pkg::DW-cfs_pkg::TYPE_CHK-N){1'b0}}, typeChk_r,
         {(cfs_pkg::TYPE_CHK-cfs_pkg::TYPE_LIN-N){1'b0}}, typeLin_r,
         {(cfs_pkg::TYPE_LIN-N){1'b0}}, typeHand_r};
    wire [cfs_pkg::DW-1:0] rdWord =
        selCtrl  ? {{(cfs_pkg::DW-1){1'b0}}, manual_r} :
        selStat  ? statWord :
        selType  ? typeWord :
        selCode  ? {{(cfs_pkg::DW-N*cfs_pkg::CW){1'b0}}, codeFlat} :
        selMout  ? {{(cfs_pkg::DW-MW){1'b0}}, mout_r} :
        selInp   ? fieldSync_r :
        selIstat ? {{(cfs_pkg::DW-N-1){1'b0}}, istat_r} :
        selImask ? {{(cfs_pkg::DW-N-1){1'b0}}, imask_r} :
        '0;

    // APB: one wait state, ready and data from flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access & ~pready;
            prdata  <= (access & ~pready & ~pwrite) ? rdWord : '0;
            pslverr <= access & ~pready & ~mapped;
        end
    end

    // Software-written state
    always_ff @(posedge core_clk) begin
        if (reset) begin
            manual_r   <= 1'b0;
            typeHand_r <= '0;
            typeLin_r  <= '0;
            typeChk_r  <= '0;
            mout_r     <= '0;
            imask_r    <= '0;
        end else if (wrEn) begin
            if (selCtrl)
                manual_r <= pwdata[cfs_pkg::CTRL_MAN]; // R16
            if (selType) begin
                typeHand_r <= pwdata[cfs_pkg::TYPE_HAND +: N];
                typeLin_r  <= pwdata[cfs_pkg::TYPE_LIN  +: N];
                typeChk_r  <= pwdata[cfs_pkg::TYPE_CHK  +: N]; // R12
            end
            if (selMout)
                mout_r <= pwdata[MW-1:0]; // R16
            if (selImask)
                imask_r <= pwdata[N:0];
        end
    end

    // Outputs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            istat_r    <= '0;
            irq        <= 1'b0;
            signalOut  <= 1'b0;
            progPermit <= 1'b1;
            devOut     <= '0;
            autoRun    <= '0;
            devInit    <= '0;
        end else begin
            istat_r    <= istatNxt;
            irq        <= |(istatNxt & imask_r);
            signalOut  <= alarmNxt; // R1 R3
            progPermit <= 1'b1; // R17
            devOut     <= outNxt;
            autoRun    <= runDev; // R15 R16
            devInit    <= initEv; // R2 R4 R14 R15
        end
    end
endmodule : cfs_supervisor

// ### sim/cfs_supervisor_assertions.sv
`timescale 1ns/1ps
module cfs_supervisor_assertions (
    // Clock and reset
    input wire logic                                   core_clk,
    input wire logic                                   reset,
    // Bus handshake
    input wire logic                                   psel,
    input wire logic                                   penable,
    input wire logic                                   pready,
    // Panel and field
    input wire logic                                   threeWirePin,
    input wire logic                                   signalOut,
    input wire logic                                   progPermit,
    input wire cfs_pkg::cfs_field_type [cfs_pkg::NDEV-1:0] fieldPin,
    // Device side
    input wire logic [cfs_pkg::NDEV*cfs_pkg::OUTW-1:0] autoOut,
    input wire logic [cfs_pkg::NDEV*cfs_pkg::OUTW-1:0] devOut,
    input wire logic [cfs_pkg::NDEV-1:0]               autoRun,
    input wire logic [cfs_pkg::NDEV-1:0]               devInit
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // Pin goes through two sync stages, so the loss must persist
    sequence sysLoss;
        $fell(threeWirePin) ##1 !threeWirePin [*2];
    endsequence
    sequence sysBack;
        $rose(threeWirePin) ##1 threeWirePin [*2];
    endsequence

    bus_ready_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    power_alarm_a: assert property (sysLoss |-> ##[0:4] signalOut)
        else $error("no alarm on system power loss");
    restart_init_a: assert property (
        sysBack |-> ##[0:4] (devInit == 4'hF))
        else $error("devices not initialised on restart");
    dev_power_a: assert property (
        $fell(fieldPin[2].ctlPower) |-> ##[1:6] !autoRun[2])
        else $error("device kept running without power");
    power_init_a: assert property (
        $rose(fieldPin[2].ctlPower) |-> ##[1:6] devInit[2])
        else $error("no init on device power restore");
    hand_stop_a: assert property (
        $rose(fieldPin[3].handSw) |-> ##[1:6] !autoRun[3])
        else $error("hand switch did not stop device");
    hand_init_a: assert property (
        $fell(fieldPin[3].handSw) |-> ##[1:6] devInit[3])
        else $error("no init on return to automatic");
    auto_pass_a: assert property (
        autoRun[1] && $past(autoRun[1])
        |-> devOut[7:4] == $past(autoOut[7:4]))
        else $error("automatic outputs not passed");
    alarm_stop_a: assert property (
        $rose(signalOut) |-> ##[0:2] (autoRun != 4'hF))
        else $error("alarm with every device running");
    permit_high_a: assert property (progPermit)
        else $error("program permit low");
endmodule : cfs_supervisor_assertions

bind cfs_supervisor cfs_supervisor_assertions chk (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pready(pready), .threeWirePin(threeWirePin), .signalOut(signalOut),
    .progPermit(progPermit), .fieldPin(fieldPin), .autoOut(autoOut),
    .devOut(devOut), .autoRun(autoRun), .devInit(devInit));

// ### sim/cfs_field_model.sv
`timescale 1ns/1ps
module cfs_field_model (
    // Clock
    input  wire logic                             core_clk,
    // Bench control
    input  wire logic                             setEn,
    input  wire logic [1:0]                       setDev,
    input  wire logic [7:0]                       setVal,
    // Field contacts, one struct per device
    output cfs_pkg::cfs_field_type [cfs_pkg::NDEV-1:0] fieldPin
);
    // Powered, idle, eyes clear until told otherwise
    initial fieldPin = {cfs_pkg::NDEV{8'h80}};

    // Contacts move right after an edge; mate cancel included
    always @(posedge core_clk) begin
        if (setEn)
            fieldPin[setDev] <= setVal;
    end
endmodule : cfs_field_model

// ### sim/test_conveyor_fault_supervisor.sv
`timescale 1ns/1ps
module test_conveyor_fault_supervisor;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        threeWirePin = 1'b1;
    logic        cancelPin = 1'b0;
    logic        signalOut;
    logic        progPermit;
    logic        irq;
    logic        setEn = 1'b0;
    logic [1:0]  setDev = 2'h0;
    logic [7:0]  setVal = 8'h80;
    logic        clrSeen = 1'b0;
    logic [3:0]  initSeen = 4'h0;
    logic [15:0] autoOut = 16'h5A5A;
    logic [15:0] devOut;
    logic [3:0]  autoRun;
    logic [3:0]  devInit;
    logic [31:0] d;
    logic        lastErr;
    logic [3:0]  ex;
    int          g;
    int          errors = 0;
    int          n_compared = 0;
    cfs_pkg::cfs_field_type [3:0] fieldPin;
    cfs_pkg::cfs_seq_type   [3:0] seqIn = '0;
    // dev, code, field, seq, type bits (chk, lin, hand)
    logic [31:0] tc [12] = '{32'h01801200, 32'h11821000, 32'h228C0401,
        32'h33880201, 32'h04A00400, 32'h15811002, 32'h26800A02,
        32'h37901006, 32'h00901002, 32'h18800102, 32'h29000000,
        32'h3AC00000};

    always #25 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        initSeen <= clrSeen ? 4'h0 : (initSeen | devInit);
    end

    cfs_field_model model (.core_clk(core_clk), .setEn(setEn),
        .setDev(setDev), .setVal(setVal), .fieldPin(fieldPin));

    cfs_supervisor uut (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .threeWirePin(threeWirePin),
        .cancelPin(cancelPin), .signalOut(signalOut),
        .progPermit(progPermit), .irq(irq), .fieldPin(fieldPin),
        .seqIn(seqIn), .autoOut(autoOut), .devOut(devOut),
        .autoRun(autoRun), .devInit(devInit));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        apb(1'b1, a, v, x);
    endtask : wr

    task automatic setField(input logic [1:0] dev, input logic [7:0] v);
        setDev <= dev;
        setVal <= v;
        setEn  <= 1'b1;
        @(posedge core_clk);
        setEn  <= 1'b0;
    endtask : setField

    task automatic test_done;
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        cmp(progPermit, 32'h1);
        apb(1'b0, cfs_pkg::REG_STAT, 32'h0, d);
        cmp(d, 32'h00000F04);
        apb(1'b0, 8'h3C, 32'h0, d);
        cmp({d[30:0], lastErr}, 32'h1);
        wr(cfs_pkg::REG_IMASK, 32'h1);
        threeWirePin <= 1'b0;
        repeat (8) @(posedge core_clk);
        cmp(signalOut, 32'h1);
        cmp(irq, 32'h1);
        apb(1'b0, cfs_pkg::REG_STAT, 32'h0, d);
        cmp(d, 32'h00000003);
        wr(cfs_pkg::REG_IMASK, 32'h0);
        repeat (2) @(posedge core_clk);
        cmp(irq, 32'h0);
        wr(cfs_pkg::REG_ISTAT, 32'h1);
        apb(1'b0, cfs_pkg::REG_ISTAT, 32'h0, d);
        cmp(d, 32'h0);
        clrSeen      <= 1'b1;
        threeWirePin <= 1'b1;
        @(posedge core_clk);
        clrSeen <= 1'b0;
        repeat (8) @(posedge core_clk);
        cmp(initSeen, 32'hF);
        apb(1'b0, cfs_pkg::REG_STAT, 32'h0, d);
        cmp(d, 32'h00000F04);
        wr(cfs_pkg::REG_CTRL, 32'h1);
        wr(cfs_pkg::REG_MOUT, 32'h0000A5C3);
        repeat (2) @(posedge core_clk);
        cmp({autoRun, devOut}, 32'h0000A5C3);
        apb(1'b0, cfs_pkg::REG_INP, 32'h0, d);
        cmp(d, 32'h80808080);
        wr(cfs_pkg::REG_CTRL, 32'h0);
        repeat (3) @(posedge core_clk);
        cmp(devOut, 32'h5A5A);
        for (int i = 0; i < 12; i++) begin
            g  = tc[i][31:28];
            ex = tc[i][27:24];
            wr(cfs_pkg::REG_TYPE, {15'h0, tc[i][2], 7'h0, tc[i][1],
                                   7'h0, tc[i][0]} << g);
            setField(g[1:0], tc[i][23:16]);
            repeat (5) @(posedge core_clk);
            seqIn[g] <= tc[i][12:8];
            @(posedge core_clk);
            seqIn[g] <= 5'h00;
            repeat (6) @(posedge core_clk);
            apb(1'b0, cfs_pkg::REG_CODE, 32'h0, d);
            cmp(d, {28'h0, ex} << (4 * g));
            cmp(signalOut, ex inside {[4'h1:4'h9]});
            cmp(autoRun, (ex != 4'h0) ? (4'hF ^ (4'h1 << g)) : 4'hF);
            clrSeen <= 1'b1;
            setField(g[1:0], 8'h80);
            clrSeen <= 1'b0;
            // Button path is exercised once, register path for the other codes below 9
            if (i == 4) begin
                cancelPin <= 1'b1;
                repeat (4) @(posedge core_clk);
                cancelPin <= 1'b0;
            end else if (ex < 4'h9) begin
                wr(cfs_pkg::REG_CMD, 32'h1);
            end
            repeat (8) @(posedge core_clk);
            cmp(initSeen, (ex != 4'h0) ? (4'h1 << g) : 4'h0);
            apb(1'b0, cfs_pkg::REG_CODE, 32'h0, d);
            cmp(d, 32'h0);
        end
        // Every device entered an alarm code at least once
        apb(1'b0, cfs_pkg::REG_ISTAT, 32'h0, d);
        cmp(d, 32'h0000001E);
        test_done();
    end
endmodule : test_conveyor_fault_supervisor
